// ===== inc/spcg_pkg.sv
// spcg_pkg: constants for the port clock gating block.
// assumes a 32-bit apb register bus and a single pclk domain.
package spcg_pkg;

  localparam int unsigned NUM_PORTS = 8;
  localparam int unsigned ADDR_W    = 12;

  // byte offsets from the system control base
  localparam logic [11:0] RUN_PORT_CLOCK_GATE_OFS   = 12'h108;
  localparam logic [11:0] SLEEP_PORT_CLOCK_GATE_OFS = 12'h118;
  localparam logic [11:0] DEEP_SLEEP_PORT_CLOCK_GATE_OFS = 12'h128;
  localparam logic [11:0] GATE_CONFIG_OFS   = 12'h130;
  localparam logic [11:0] FAULT_STATUS_OFS  = 12'h134;
  localparam logic [11:0] FAULT_MASK_OFS    = 12'h138;
  localparam logic [11:0] PORT_READY_OFS    = 12'h13c;

  // reset values
  localparam logic [7:0] GATE_RST   = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] MASK_RST   = 8'h00;
  localparam logic       AUTO_RST   = 1'b0;

  // field positions inside the gating registers
  localparam int unsigned PORT_A_CLOCK_ON = 0;
  localparam int unsigned PORT_H_CLOCK_ON = 7;
  // field position inside the gate config register
  localparam int unsigned AUTO_CLOCK_GATE_ENABLE = 0;

  // processor power mode as given by the core
  localparam logic [1:0] PMODE_RUN   = 2'h0;
  localparam logic [1:0] PMODE_SLEEP = 2'h1;
  localparam logic [1:0] PMODE_DEEP  = 2'h2;

  // cycles from gate enable to the port clock being usable
  localparam int unsigned READY_DELAY_CYC = 1;

endpackage

// ===== rtl/spcg_clk_gate.sv
// spcg_clk_gate: glitch-free clock gate for one port.
// assumes enable comes from flops on the rising edge of clk_in.
`timescale 1ns/1ps
module spcg_clk_gate (
  // clock in
  input  wire logic clk_in,
  // control
  input  wire logic enable,
  // gated clock out
  output wire logic clk_out
);

  logic en_latch;

  // transparent while clock is low, so the and-gate never sees a
  // change of enable during the high phase
  always_latch begin
    if (!clk_in) begin
      en_latch <= enable;
    end
  end

  assign clk_out = clk_in & en_latch;

endmodule

// ===== rtl/spcg_top.sv
// spcg_top: port clock gating by power mode, apb registers, faults.
// assumes power_mode and port_req come from logic on pclk and that
// the interconnect turns port_fault into a bus error for the access.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps

module spcg_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  // processor power mode
  input  wire logic [1:0]  power_mode,
  // port access requests and answers
  input  wire logic [7:0]  port_req,
  output wire logic [7:0]  port_fault,
  output wire logic [7:0]  port_ready,
  // gated port clocks
  output wire logic [7:0]  port_clk,
  // interrupt
  output wire logic        irq
);

  logic [7:0]  run_gate_ff;
  logic [7:0]  sleep_gate_ff;
  logic [7:0]  deep_gate_ff;
  logic        auto_gate_ff;
  logic [7:0]  fault_status_ff;
  logic [7:0]  fault_mask_ff;
  logic [7:0]  gate_en_ff;
  logic [7:0]  clk_on_ff;
  logic [31:0] prdata_ff;

  logic [7:0]  nxt_gate_en;
  logic [7:0]  nxt_fault_status;
  logic [31:0] nxt_prdata;

  // pick one 8-bit field from the register map
  function automatic logic [7:0] read_field(
    input logic [11:0] addr,
    input logic [7:0]  run_g,
    input logic [7:0]  slp_g,
    input logic [7:0]  deep_g,
    input logic        auto_g,
    input logic [7:0]  stat,
    input logic [7:0]  mask,
    input logic [7:0]  rdy
  );
    logic [7:0] val;
    val = 8'h00;
    case (addr)
      spcg_pkg::RUN_PORT_CLOCK_GATE_OFS:       val = run_g;
      spcg_pkg::SLEEP_PORT_CLOCK_GATE_OFS:     val = slp_g;
      spcg_pkg::DEEP_SLEEP_PORT_CLOCK_GATE_OFS: val = deep_g;
      spcg_pkg::GATE_CONFIG_OFS:               val = {7'h00, auto_g};
      spcg_pkg::FAULT_STATUS_OFS:              val = stat;
      spcg_pkg::FAULT_MASK_OFS:                val = mask;
      spcg_pkg::PORT_READY_OFS:                val = rdy;
      default:                                 val = 8'h00;
    endcase
    return val;
  endfunction

  // true when addr names a mapped register
  function automatic logic addr_hit(input logic [11:0] addr);
    logic hit;
    hit = (addr == spcg_pkg::RUN_PORT_CLOCK_GATE_OFS)
       || (addr == spcg_pkg::SLEEP_PORT_CLOCK_GATE_OFS)
       || (addr == spcg_pkg::DEEP_SLEEP_PORT_CLOCK_GATE_OFS)
       || (addr == spcg_pkg::GATE_CONFIG_OFS)
       || (addr == spcg_pkg::FAULT_STATUS_OFS)
       || (addr == spcg_pkg::FAULT_MASK_OFS)
       || (addr == spcg_pkg::PORT_READY_OFS);
    return hit;
  endfunction

  // bus decode
  wire logic setup_ph  = psel & ~penable;
  wire logic access_ph = psel & penable;
  wire logic mapped    = addr_hit(paddr);
  wire logic wr_ok     = access_ph & pwrite & mapped;
  wire logic wr_run    = wr_ok
                         & (paddr == spcg_pkg::RUN_PORT_CLOCK_GATE_OFS);
  wire logic wr_sleep  = wr_ok
                         & (paddr == spcg_pkg::SLEEP_PORT_CLOCK_GATE_OFS);
  wire logic wr_deep   = wr_ok
                         & (paddr == spcg_pkg::DEEP_SLEEP_PORT_CLOCK_GATE_OFS);
  wire logic wr_cfg    = wr_ok & (paddr == spcg_pkg::GATE_CONFIG_OFS);
  wire logic wr_stat   = wr_ok & (paddr == spcg_pkg::FAULT_STATUS_OFS);
  wire logic wr_mask   = wr_ok & (paddr == spcg_pkg::FAULT_MASK_OFS);

  // zero wait states; unmapped addresses answer with an error
  // writes to the read-only ready register are dropped quietly
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~mapped;

  // read data is captured in the setup phase so prdata is a flop
  assign nxt_prdata = setup_ph & ~pwrite
                    ? {24'h000000, read_field(paddr, run_gate_ff,
                        sleep_gate_ff, deep_gate_ff, auto_gate_ff,
                        fault_status_ff, fault_mask_ff, port_ready)}
                    : prdata_ff;
  assign prdata = prdata_ff;

  // mode selection: without auto gating the run register always rules
  wire logic use_sleep = auto_gate_ff
                       & (power_mode == spcg_pkg::PMODE_SLEEP);
  wire logic use_deep  = auto_gate_ff
                       & (power_mode == spcg_pkg::PMODE_DEEP);
  assign nxt_gate_en = use_sleep ? sleep_gate_ff
                     : use_deep  ? deep_gate_ff
                     : run_gate_ff;

  // a port only counts as ready one edge after its enable rose, when
  // the gated clock gives the rising edge of its first pulse
  assign port_ready = gate_en_ff & clk_on_ff;

  // faults are answered in the same cycle as the request
  assign port_fault = port_req & ~port_ready;

  // sticky fault bits; a new fault wins over a write-one clear
  assign nxt_fault_status = (fault_status_ff
                            & ~(wr_stat ? pwdata[7:0] : 8'h00))
                            | port_fault;
  assign irq = |(fault_status_ff & fault_mask_ff);

  // registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_gate_ff   <= spcg_pkg::GATE_RST;
      sleep_gate_ff <= spcg_pkg::GATE_RST;
      deep_gate_ff  <= spcg_pkg::GATE_RST;
      auto_gate_ff  <= spcg_pkg::AUTO_RST;
      fault_mask_ff <= spcg_pkg::MASK_RST;
    end else begin
      if (wr_run) begin
        run_gate_ff <= pwdata[7:0];
      end
      if (wr_sleep) begin
        sleep_gate_ff <= pwdata[7:0];
      end
      if (wr_deep) begin
        deep_gate_ff <= pwdata[7:0];
      end
      if (wr_cfg) begin
        auto_gate_ff <= pwdata[spcg_pkg::AUTO_CLOCK_GATE_ENABLE];
      end
      if (wr_mask) begin
        fault_mask_ff <= pwdata[7:0];
      end
    end
  end

  // hardware state; clk_on lags gate_en by one edge so a port is only
  // reported ready once its gated clock has run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_en_ff      <= spcg_pkg::GATE_RST;
      clk_on_ff       <= spcg_pkg::GATE_RST;
      fault_status_ff <= spcg_pkg::STATUS_RST;
      prdata_ff       <= 32'h00000000;
    end else begin
      gate_en_ff      <= nxt_gate_en;
      clk_on_ff       <= gate_en_ff;
      fault_status_ff <= nxt_fault_status;
      prdata_ff       <= nxt_prdata;
    end
  end

  // one gate cell per port, bit n drives port n only
  genvar gi;
  generate
    for (gi = spcg_pkg::PORT_A_CLOCK_ON;
         gi <= spcg_pkg::PORT_H_CLOCK_ON; gi++) begin : g_port
      spcg_clk_gate u_gate (
        .clk_in  (pclk),
        .enable  (gate_en_ff[gi]),
        .clk_out (port_clk[gi])
      );
    end
  endgenerate

  // checks
  logic seen_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_ff <= 1'b0;
    end else begin
      seen_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_reset_clear;
    !seen_ff |-> (sleep_gate_ff == 8'h00) && (gate_en_ff == 8'h00)
                 && (port_ready == 8'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("gating not cleared after reset");

  property p_fault_gated;
    (port_req & ~gate_en_ff) != 8'h00
      |-> (port_fault & ~gate_en_ff) == (port_req & ~gate_en_ff);
  endproperty
  a_fault_gated: assert property (p_fault_gated)
    else $error("access to gated port not faulted");

  property p_fault_sticky;
    port_fault != 8'h00
      |=> (fault_status_ff & $past(port_fault)) == $past(port_fault);
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("fault not recorded in status");

  property p_ready_only_enabled;
    (port_ready & ~gate_en_ff) == 8'h00;
  endproperty
  a_ready_only_enabled: assert property (p_ready_only_enabled)
    else $error("port ready while its clock is off");

  property p_ready_waits;
    (port_ready & ~$past(gate_en_ff)) == 8'h00;
  endproperty
  a_ready_waits: assert property (p_ready_waits)
    else $error("port ready before its clock ran");

  property p_run_rules;
    !auto_gate_ff |=> gate_en_ff == $past(run_gate_ff);
  endproperty
  a_run_rules: assert property (p_run_rules)
    else $error("gating not from run register");

  property p_sleep_rules;
    auto_gate_ff && (power_mode == spcg_pkg::PMODE_SLEEP)
      |=> gate_en_ff == $past(sleep_gate_ff);
  endproperty
  a_sleep_rules: assert property (p_sleep_rules)
    else $error("sleep mode not using sleep register");

  property p_sleep_write;
    psel && penable && pwrite
      && (paddr == spcg_pkg::SLEEP_PORT_CLOCK_GATE_OFS)
      |=> sleep_gate_ff == $past(pwdata[7:0]);
  endproperty
  a_sleep_write: assert property (p_sleep_write)
    else $error("sleep register write lost");

  property p_sleep_read;
    psel && !penable && !pwrite
      && (paddr == spcg_pkg::SLEEP_PORT_CLOCK_GATE_OFS)
      |=> prdata_ff == {24'h000000, $past(sleep_gate_ff)};
  endproperty
  a_sleep_read: assert property (p_sleep_read)
    else $error("sleep register read wrong");

  property p_upper_zero;
    prdata_ff[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("reserved bits not zero");

  property p_irq_follow;
    (fault_status_ff & fault_mask_ff) != 8'h00 |-> irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow)
    else $error("interrupt missing");

  property p_irq_quiet;
    (fault_status_ff & fault_mask_ff) == 8'h00 |-> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt without unmasked fault");

  property p_fault_clear;
    psel && penable && pwrite && (paddr == spcg_pkg::FAULT_STATUS_OFS)
      && ((pwdata[7:0] & port_fault) == 8'h00)
      |=> (fault_status_ff & $past(pwdata[7:0])) == 8'h00;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault status not cleared by write one");

  property p_deep_rules;
    auto_gate_ff && (power_mode == spcg_pkg::PMODE_DEEP)
      |=> gate_en_ff == $past(deep_gate_ff);
  endproperty
  a_deep_rules: assert property (p_deep_rules)
    else $error("deep sleep mode not using deep register");

  property p_run_mode_rules;
    (power_mode != spcg_pkg::PMODE_SLEEP)
      && (power_mode != spcg_pkg::PMODE_DEEP)
      |=> gate_en_ff == $past(run_gate_ff);
  endproperty
  a_run_mode_rules: assert property (p_run_mode_rules)
    else $error("run mode not using run register");

  property p_run_write;
    psel && penable && pwrite
      && (paddr == spcg_pkg::RUN_PORT_CLOCK_GATE_OFS)
      |=> run_gate_ff == $past(pwdata[7:0]);
  endproperty
  a_run_write: assert property (p_run_write)
    else $error("run register write lost");

  property p_deep_write;
    psel && penable && pwrite
      && (paddr == spcg_pkg::DEEP_SLEEP_PORT_CLOCK_GATE_OFS)
      |=> deep_gate_ff == $past(pwdata[7:0]);
  endproperty
  a_deep_write: assert property (p_deep_write)
    else $error("deep sleep register write lost");

  property p_sleep_no_err;
    psel && penable && (paddr == spcg_pkg::SLEEP_PORT_CLOCK_GATE_OFS)
      |-> !pslverr;
  endproperty
  a_sleep_no_err: assert property (p_sleep_no_err)
    else $error("sleep register access answered with error");

  // ready exactly one edge after the enable, so no early access
  property p_ready_timing;
    port_ready == (gate_en_ff & $past(gate_en_ff));
  endproperty
  a_ready_timing: assert property (p_ready_timing)
    else $error("port ready not one edge after enable");

  c_sleep_write: cover property (psel && penable && pwrite
    && (paddr == spcg_pkg::SLEEP_PORT_CLOCK_GATE_OFS));
  c_fault: cover property (port_fault != 8'h00);
  c_sleep_ready: cover property (use_sleep && port_ready != 8'h00);
  c_irq: cover property (irq);
  c_deep: cover property (use_deep && gate_en_ff != 8'h00);

endmodule

// ===== dv/tb_spcg_top.sv
// tb_spcg_top: apb register and port gating tests for spcg_top.
// assumes a zero-wait apb slave and port_ready within three edges
// of a gate write or a power mode change.
`timescale 1ns/1ps
module tb_spcg_top;
  localparam logic [11:0] RUN  = spcg_pkg::RUN_PORT_CLOCK_GATE_OFS;
  localparam logic [11:0] SLP  = spcg_pkg::SLEEP_PORT_CLOCK_GATE_OFS;
  localparam logic [11:0] DEEP = spcg_pkg::DEEP_SLEEP_PORT_CLOCK_GATE_OFS;
  localparam logic [11:0] CFG  = spcg_pkg::GATE_CONFIG_OFS;
  localparam logic [11:0] FST  = spcg_pkg::FAULT_STATUS_OFS;
  localparam logic [11:0] FMK  = spcg_pkg::FAULT_MASK_OFS;
  localparam logic [11:0] RDY  = spcg_pkg::PORT_READY_OFS;

  // clock, reset and bus
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // ports and power
  logic [1:0]  power_mode;
  logic [7:0]  port_req;
  logic [7:0]  port_fault;
  logic [7:0]  port_ready;
  logic [7:0]  port_clk;
  logic        irq;
  // bench state
  int          bad_count;
  int          total_checks;
  logic [31:0] rd;
  logic        err;
  logic [11:0] ofs [7];

  spcg_top u_spcg_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_mode(power_mode),
    .port_req(port_req), .port_fault(port_fault),
    .port_ready(port_ready), .port_clk(port_clk), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request held from setup until the edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20) begin
      bad_count++;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input string nm, input logic [11:0] a,
                      input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  // gated clock is sampled mid high phase: high only if enabled
  task automatic gate_chk(input logic [7:0] exp);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk("port_ready", {24'h0, port_ready}, {24'h0, exp});
    @(posedge pclk);
    #10;
    chk("port_clk", {24'h0, port_clk}, {24'h0, exp});
  endtask

  task automatic mode_chk(input logic [1:0] m, input logic [7:0] exp);
    @(posedge pclk);
    power_mode <= m;
    gate_chk(exp);
  endtask

  task automatic req_chk(input logic [7:0] r, input logic [7:0] exp);
    @(posedge pclk);
    port_req <= r;
    @(negedge pclk);
    chk("port_fault", {24'h0, port_fault}, {24'h0, exp});
    @(posedge pclk);
    port_req <= 8'h00;
  endtask

  task automatic irq_chk(input logic exp);
    @(negedge pclk);
    chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask

  initial begin
    #400000;
    bad_count++;
    summarize();
  end

  initial begin
    ofs = '{RUN, SLP, DEEP, CFG, FST, FMK, RDY};
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    power_mode = spcg_pkg::PMODE_RUN;
    port_req = 8'h00;
    bad_count = 0;
    total_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ofs[i]) rchk("reset_value", ofs[i], 32'h0);
    apb(1'b0, 12'h200, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    chk("pready", {31'h0, pready}, 32'h1);
    req_chk(8'hff, 8'hff);
    wr(SLP, 32'hffff_ffff);
    rchk("sleep_gate", SLP, 32'h0000_00ff);
    chk("sleep_err", {31'h0, err}, 32'h0);
    gate_chk(8'h00);
    wr(RUN, 32'h0000_0005);
    gate_chk(8'h05);
    req_chk(8'h03, 8'h02);
    rchk("fault_status", FST, 32'h0000_00ff);
    irq_chk(1'b0);
    wr(FMK, 32'h0000_0080);
    irq_chk(1'b1);
    wr(FST, 32'h0000_0080);
    rchk("fault_status", FST, 32'h0000_007f);
    irq_chk(1'b0);
    // auto gating on: the power mode picks the register
    wr(CFG, 32'h0000_0001);
    mode_chk(spcg_pkg::PMODE_SLEEP, 8'hff);
    mode_chk(spcg_pkg::PMODE_DEEP, 8'h00);
    wr(DEEP, 32'h0000_0030);
    gate_chk(8'h30);
    mode_chk(2'h3, 8'h05);
    mode_chk(spcg_pkg::PMODE_SLEEP, 8'hff);
    wr(SLP, 32'h0000_000a);
    gate_chk(8'h0a);
    rchk("port_ready_reg", RDY, 32'h0000_000a);
    wr(RDY, 32'h0000_00ff);
    rchk("port_ready_reg", RDY, 32'h0000_000a);
    req_chk(8'hf0, 8'hf0);
    wr(CFG, 32'h0000_0000);
    gate_chk(8'h05);
    // reset in mid-run must drop every gate and the status again
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk("sleep_after_rst", SLP, 32'h0);
    rchk("status_after_rst", FST, 32'h0);
    gate_chk(8'h00);
    // an access right after enabling still faults: clock not yet run
    wr(RUN, 32'h0000_0001);
    req_chk(8'h01, 8'h01);
    gate_chk(8'h01);
    summarize();
  end
endmodule
